// ==== sltc_pkg.sv ====
// constants and carrier types shared by the link self-test controller
// assumes a single 25 MHz system clock and byte-wide register accesses
`default_nettype none
package sltc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_TX_PORT_SEL = 8'h32;
    localparam logic [7:0] ADDR_TX_LO       = 8'h33;
    localparam logic [7:0] ADDR_TX_HI       = 8'h3a;
    localparam logic [7:0] ADDR_RX_LO       = 8'h46;
    localparam logic [7:0] ADDR_RX_HI       = 8'h7f;
    localparam logic [7:0] ADDR_PAGE_SEL    = 8'h4c;
    localparam logic [7:0] ADDR_TALLY       = 8'h57;
    localparam logic [7:0] ADDR_IND_PAGE    = 8'hb0;
    localparam logic [7:0] ADDR_IND_OFS     = 8'hb1;
    localparam logic [7:0] ADDR_IND_DATA    = 8'hb2;
    localparam logic [7:0] ADDR_TEST_CTRL   = 8'hb3;
    localparam logic [7:0] ADDR_DBG_LO      = 8'hd0;
    localparam logic [7:0] ADDR_DBG_HI      = 8'hdf;
    localparam logic [7:0] ADDR_DBG_STAT    = 8'hd0;
    // ****************************************
    // field positions and codes
    // ****************************************
    localparam int         CTRL_EN_BIT      = 0;
    localparam int         CTRL_CLK_LSB     = 1;
    localparam int         CTRL_GATE_LSB    = 6;
    localparam int         PAGE_RD_LSB      = 4;
    localparam int         DBG_REMOTE_BIT   = 5;
    localparam int         TX_SEL_BIT       = 0;
    localparam int         CSI_EN_BIT       = 0;
    localparam int         PGEN_EN_BIT      = 0;
    localparam logic [3:0] PGEN_CTL_OFS     = 4'h1;
    localparam logic [1:0] GATE_ON          = 2'b10;
    localparam logic [7:0] TALLY_NO_LOCK    = 8'hff;
    localparam logic [7:0] TALLY_MAX        = 8'hfe;
    localparam logic [7:0] SER_TEST_REG     = 8'h14;
    localparam logic [7:0] SER_TEST_OFF     = 8'h00;
    localparam logic [7:0] DBG_RW_MASK      = 8'hdf;
    // ****************************************
    // reset values and sizes
    // ****************************************
    localparam logic [7:0] RST_CTRL         = 8'h00;
    localparam logic [7:0] RST_PAGE_SEL     = 8'h01;
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam int         NPORTS           = 4;
    localparam int         NTX_REGS         = 8;
    localparam int         NPGEN_REGS       = 16;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sltc_req_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sltc_rsp_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } sltc_bcw_t;
endpackage
`default_nettype wire

// ==== sltc_port_check.sv ====
// per-port pseudo-random word checker with saturating error tally
// assumes received words arrive on the system clock; lock is already synchronised
`default_nettype none
module sltc_port_check
    import sltc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         i_clk,     // system clock
    input  wire logic         i_rst_n,   // synchronised reset
    input  wire logic         i_clear,   // test start pulse
    input  wire logic         i_run,     // test running
    input  wire logic         i_lock,    // receiver lock
    input  wire logic         i_valid,   // word strobe
    input  wire logic [W-1:0] i_word,    // received word
    output logic        [7:0] o_tally,   // error tally as read
    output logic              o_pass     // pass indication
);
    logic [W-1:0] prev;
    logic         primed;
    logic         seen_lock;
    logic         lock_fail;
    logic   [7:0] count;
    logic         err;

    // prediction from last word: x^7+x^6+1, msb first, self-synchronising
    function automatic logic [W-1:0] predict(input logic [W-1:0] p);
        logic [6:0]   h;
        logic [W-1:0] r;
        h = p[6:0];
        r = '0;
        for (int i = W - 1; i >= 0; i--)
        begin
            r[i] = h[6] ^ h[5];
            h = {h[5:0], r[i]};
        end
        return r;
    endfunction

    wire word_ok = (predict(prev) == i_word);
    wire next_err = i_run && i_lock && i_valid && primed && !word_ok;
    assign o_tally = (lock_fail || !seen_lock) ? TALLY_NO_LOCK : count;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prev      <= '0;
            primed    <= 1'b0;
            seen_lock <= 1'b0;
            lock_fail <= 1'b0;
            count     <= 8'h00;
            err       <= 1'b0;
            o_pass    <= 1'b1;
        end
        else
        begin
            err    <= next_err;
            o_pass <= !next_err;
            if (i_valid && i_lock)
                prev <= i_word;
            if (i_clear)
            begin
                primed    <= 1'b0;
                seen_lock <= i_lock;
                lock_fail <= 1'b0;
                count     <= 8'h00;
            end
            else if (i_run)
            begin
                primed <= primed | (i_valid & i_lock);
                if (i_lock)
                    seen_lock <= 1'b1;
                else if (seen_lock)
                    lock_fail <= 1'b1;
                if (next_err && count != TALLY_MAX)
                    count <= count + 8'h01;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_sat;
        count <= TALLY_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("tally passed its normal maximum");
    property p_fail_reads_ff;
        i_run && !i_clear && seen_lock && !i_lock |=> o_tally == TALLY_NO_LOCK;
    endproperty
    a_fail_reads_ff: assert property (p_fail_reads_ff) else $error("lost lock not shown as all ones");
    property p_err_low;
        err |-> !o_pass;
    endproperty
    a_err_low: assert property (p_err_low) else $error("pass stayed high on error");
    property p_pass_back;
        err ##1 !err |-> o_pass;
    endproperty
    a_pass_back: assert property (p_pass_back) else $error("pass did not return high");
    property p_clear;
        i_clear |=> count == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("tally not cleared at start");
endmodule
`default_nettype wire

// ==== sltc_bc_writer.sv ====
// back-channel write sequencer: at most one serializer register write per start or stop
// assumes the back-channel engine holds ready low while it is busy
`default_nettype none
module sltc_bc_writer
    import sltc_pkg::*;
(
    input  wire logic       i_clk,      // system clock
    input  wire logic       i_rst_n,    // synchronised reset
    input  wire logic       i_start,    // test start pulse
    input  wire logic       i_stop,     // test stop pulse
    input  wire logic [1:0] i_clk_pick, // clock pick captured at start
    input  wire logic       i_ready,    // back channel accepts
    output sltc_bcw_t       o_bcw       // write request
);
    typedef enum logic {ST_IDLE, ST_SEND} sltc_bcst_t;
    sltc_bcst_t state;
    logic       pend;
    logic [7:0] pend_data;

    // serializer test register: bit 0 enters test, bits 2:1 pick the clock
    wire [7:0] cmd_data = i_start ? {5'h00, i_clk_pick, 1'b1} : SER_TEST_OFF;
    wire       cmd      = i_start | i_stop;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state     <= ST_IDLE;
            pend      <= 1'b0;
            pend_data <= 8'h00;
            o_bcw     <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (cmd)
                    begin
                        o_bcw <= '{valid: 1'b1, addr: SER_TEST_REG, data: cmd_data};
                        state <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    // a command arriving mid-write is held, newest one wins
                    if (cmd)
                    begin
                        pend      <= 1'b1;
                        pend_data <= cmd_data;
                    end
                    if (i_ready)
                    begin
                        if (pend && !cmd)
                        begin
                            o_bcw.data <= pend_data;
                            pend       <= 1'b0;
                        end
                        else if (cmd)
                        begin
                            o_bcw.data <= cmd_data;
                            pend       <= 1'b0;
                        end
                        else
                        begin
                            o_bcw.valid <= 1'b0;
                            state       <= ST_IDLE;
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== sltc_top.sv ====
// link self-test controller: test control, paged per-port access, pass outputs
// assumes request ports come from i2c and remote control-channel logic on this clock
//
// Behaviour
// - writing 0x01 starts test, zero stops
// - start sends one serializer test-mode write over back-channel
// - each port checks words against expected sequence
// - eight-bit per-port tally read at 0x57
// - no lock reads 0xff, counts stop 0xfe
// - pass output pulses low per error
// - bit 5 of port_debug_status shows remote test active
// - control bits 7:6 gate outputs, 10 enables
// - during test with gating 10, csi stays lp11 unless pattern generator on
// - clock pick copied to serializer 0x14 bits 2:1
// - clock pick sampled only at test start
// - registers reachable locally and from remote side
// - rx pages: read code, write enable bits
// - debug pages use the same port selection
// - tx pages reach port 0 when 0x32 bit0
// - pattern settings via page, offset, data registers
`default_nettype none
module sltc_top
    import sltc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic                 I_CLK_SYS,      // 25 MHz system clock
    input  wire logic                 I_RSTN,         // async reset, active low
    input  wire sltc_pkg::sltc_req_t  I_LOC_REQ,      // local i2c register request
    output sltc_pkg::sltc_rsp_t       O_LOC_RSP,      // local read answer
    input  wire sltc_pkg::sltc_req_t  I_REM_REQ,      // remote channel register request
    output sltc_pkg::sltc_rsp_t       O_REM_RSP,      // remote read answer
    input  wire logic [3:0]           I_RX_LOCK,      // receiver lock pins
    input  wire logic [3:0]           I_SER_ACT,      // serializer test-active report
    input  wire logic [3:0]           I_RX_VALID,     // received word strobes
    input  wire logic [4*W-1:0]       I_RX_WORD,      // received words, port 0 low
    output sltc_pkg::sltc_bcw_t       O_BC_WR,        // back-channel write request
    input  wire logic                 I_BC_READY,     // back channel accepts
    output logic [3:0]                O_PASS,         // pass indication per port
    output logic                      O_OUT_EN,       // hub outputs enabled
    output logic                      O_CSI_LP11,     // csi forced to lp11
    output logic                      O_CSI_EN,       // csi transmitter enable
    output logic                      O_PGEN_EN,      // pattern generator enable
    output logic                      O_TEST_ACTIVE   // self test running
);
    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
    begin
        if (!I_RSTN)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end
        else
        begin
            pin_meta <= {I_SER_ACT, I_RX_LOCK};
            pin_sync <= pin_meta;
        end
    end
    wire [3:0] lock_s = pin_sync[3:0];
    wire [3:0] act_s  = pin_sync[7:4];

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] ctrl;
    logic [7:0] page_sel;
    logic [7:0] tx_sel;
    logic [7:0] tx_regs   [NTX_REGS];
    logic [7:0] ind_page;
    logic [7:0] ind_ofs;
    logic [7:0] pgen_regs [NPGEN_REGS];
    logic [7:0] dbg_regs  [NPORTS];
    logic [1:0] clk_pick;
    logic [7:0] tally     [NPORTS];

    // local wins a same-cycle write collision; the remote write is dropped
    wire sltc_req_t wreq   = I_LOC_REQ.wr ? I_LOC_REQ : I_REM_REQ;
    wire            wr     = I_LOC_REQ.wr | I_REM_REQ.wr;
    wire [7:0]      wa     = wreq.addr;
    wire [7:0]      wd     = wreq.wdata;
    // reads follow one port, writes may land on several ports at once
    wire [1:0]      rd_port = page_sel[PAGE_RD_LSB +: 2];
    wire [3:0]      wr_ports = page_sel[3:0];
    wire            test_on = ctrl[CTRL_EN_BIT];
    wire            ctrl_wr = wr && wa == ADDR_TEST_CTRL;
    wire            start   = ctrl_wr && wd[CTRL_EN_BIT] && !test_on;
    wire            stop    = ctrl_wr && !wd[CTRL_EN_BIT] && test_on;
    wire            tx_hit  = wa >= ADDR_TX_LO && wa <= ADDR_TX_HI && tx_sel[TX_SEL_BIT];
    wire [2:0]      tx_idx  = 3'(wa - ADDR_TX_LO);
    wire            ind_ok  = ind_page == 8'h00 && ind_ofs < 8'(NPGEN_REGS);
    wire            pgen_on = pgen_regs[PGEN_CTL_OFS][PGEN_EN_BIT];
    wire            gate_on = ctrl[CTRL_GATE_LSB +: 2] == GATE_ON;
    wire            next_out_en = !test_on || gate_on;
    wire            next_lp11 = test_on && gate_on && !pgen_on;

    // read mux shared by both request ports
    function automatic logic [7:0] rd_value(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_TEST_CTRL)
            v = ctrl;
        else if (a == ADDR_PAGE_SEL)
            v = page_sel;
        else if (a == ADDR_TX_PORT_SEL)
            v = tx_sel;
        else if (a >= ADDR_TX_LO && a <= ADDR_TX_HI && tx_sel[TX_SEL_BIT])
            v = tx_regs[3'(a - ADDR_TX_LO)];
        else if (a == ADDR_TALLY)
            v = tally[rd_port];
        else if (a == ADDR_DBG_STAT)
            v = (dbg_regs[rd_port] & DBG_RW_MASK) | (8'(act_s[rd_port]) << DBG_REMOTE_BIT);
        else if (a == ADDR_IND_PAGE)
            v = ind_page;
        else if (a == ADDR_IND_OFS)
            v = ind_ofs;
        else if (a == ADDR_IND_DATA && ind_ok)
            v = pgen_regs[ind_ofs[3:0]];
        return v;
    endfunction

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl     <= RST_CTRL;
            page_sel <= RST_PAGE_SEL;
            tx_sel   <= RST_BYTE;
            ind_page <= RST_BYTE;
            ind_ofs  <= RST_BYTE;
            clk_pick <= 2'b00;
            for (int i = 0; i < NTX_REGS; i++)
                tx_regs[i] <= RST_BYTE;
            for (int i = 0; i < NPGEN_REGS; i++)
                pgen_regs[i] <= RST_BYTE;
            for (int i = 0; i < NPORTS; i++)
                dbg_regs[i] <= RST_BYTE;
        end
        else if (wr)
        begin
            if (ctrl_wr)
                ctrl <= wd;
            if (start)
                clk_pick <= wd[CTRL_CLK_LSB +: 2];
            if (wa == ADDR_PAGE_SEL)
                page_sel <= wd;
            if (wa == ADDR_TX_PORT_SEL)
                tx_sel <= wd;
            if (tx_hit)
                tx_regs[tx_idx] <= wd;
            if (wa == ADDR_IND_PAGE)
                ind_page <= wd;
            if (wa == ADDR_IND_OFS)
                ind_ofs <= wd;
            if (wa == ADDR_IND_DATA && ind_ok)
                pgen_regs[ind_ofs[3:0]] <= wd;
            for (int i = 0; i < NPORTS; i++)
                if (wa == ADDR_DBG_STAT && wr_ports[i])
                    dbg_regs[i] <= wd & DBG_RW_MASK;
        end
    end

    // ****************************************
    // answers and registered outputs
    // ****************************************
    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_LOC_RSP     <= '0;
            O_REM_RSP     <= '0;
            O_OUT_EN      <= 1'b1;
            O_CSI_LP11    <= 1'b0;
            O_CSI_EN      <= 1'b0;
            O_PGEN_EN     <= 1'b0;
            O_TEST_ACTIVE <= 1'b0;
        end
        else
        begin
            O_LOC_RSP     <= '{valid: I_LOC_REQ.rd, data: rd_value(I_LOC_REQ.addr)};
            O_REM_RSP     <= '{valid: I_REM_REQ.rd, data: rd_value(I_REM_REQ.addr)};
            O_OUT_EN      <= next_out_en;
            O_CSI_LP11    <= next_lp11;
            // csi enable is forced off while the test holds the outputs disabled
            O_CSI_EN      <= tx_regs[0][CSI_EN_BIT] && !(test_on && !gate_on);
            O_PGEN_EN     <= pgen_on;
            O_TEST_ACTIVE <= test_on;
        end
    end

    // ****************************************
    // port checkers and back-channel writer
    // ****************************************
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        sltc_port_check #(
            .W       (W)
        ) u_chk (
            .i_clk   (I_CLK_SYS),
            .i_rst_n (rst_n),
            .i_clear (start),
            .i_run   (test_on),
            .i_lock  (lock_s[p]),
            .i_valid (I_RX_VALID[p]),
            .i_word  (I_RX_WORD[p*W +: W]),
            .o_tally (tally[p]),
            .o_pass  (O_PASS[p])
        );
    end

    // the writer sees the new pick in the start cycle, before clk_pick settles
    sltc_bc_writer u_bcw (
        .i_clk      (I_CLK_SYS),
        .i_rst_n    (rst_n),
        .i_start    (start),
        .i_stop     (stop),
        .i_clk_pick (wd[CTRL_CLK_LSB +: 2]),
        .i_ready    (I_BC_READY),
        .o_bcw      (O_BC_WR)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!rst_n);
    sequence s_start_cmd;
        start ##1 test_on;
    endsequence
    sequence s_ser_enter;
        ##[0:2] (O_BC_WR.valid && O_BC_WR.addr == SER_TEST_REG && O_BC_WR.data[0]);
    endsequence
    property p_start_write;
        s_start_cmd |-> s_ser_enter;
    endproperty
    a_start_write: assert property (p_start_write) else $error("no serializer write after start");
    property p_stop_write;
        stop |-> ##[1:6] (O_BC_WR.valid && O_BC_WR.data == SER_TEST_OFF);
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("no serializer write after stop");
    property p_clk_copy;
        O_BC_WR.valid && O_BC_WR.data[0] && test_on |-> O_BC_WR.data[2:1] == clk_pick;
    endproperty
    a_clk_copy: assert property (p_clk_copy) else $error("clock pick not copied");
    property p_clk_hold;
        test_on && !start ##1 test_on |-> $stable(clk_pick);
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock pick changed mid test");
    property p_gate;
        ##1 O_OUT_EN == $past(next_out_en);
    endproperty
    a_gate: assert property (p_gate) else $error("output gating wrong");
    property p_lp11;
        test_on && gate_on && !pgen_on ##1 test_on && gate_on && !pgen_on |-> O_CSI_LP11;
    endproperty
    a_lp11: assert property (p_lp11) else $error("csi not idle during test");
    property p_tally_read;
        I_LOC_REQ.rd && I_LOC_REQ.addr == ADDR_TALLY |=> O_LOC_RSP.valid && O_LOC_RSP.data == $past(tally[rd_port]);
    endproperty
    a_tally_read: assert property (p_tally_read) else $error("tally read wrong port");
    property p_remote_bit;
        I_LOC_REQ.rd && I_LOC_REQ.addr == ADDR_DBG_STAT |=> O_LOC_RSP.data[5] == $past(act_s[rd_port]);
    endproperty
    a_remote_bit: assert property (p_remote_bit) else $error("remote active bit wrong");
    property p_tx_page;
        wr && wa == ADDR_TX_LO && !tx_sel[TX_SEL_BIT] |=> $stable(tx_regs[0]);
    endproperty
    a_tx_page: assert property (p_tx_page) else $error("tx page written while deselected");
    // gating codes other than 10 keep the outputs off for the whole test
    property p_gate_off;
        test_on && !gate_on |=> !O_OUT_EN;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("outputs not gated off");
    property p_stop_off;
        stop |=> ##1 !O_TEST_ACTIVE;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("test still active after stop");
    property p_rem_tally;
        I_REM_REQ.rd && I_REM_REQ.addr == ADDR_TALLY |=> O_REM_RSP.valid && O_REM_RSP.data == $past(tally[rd_port]);
    endproperty
    a_rem_tally: assert property (p_rem_tally) else $error("remote tally read wrong");
endmodule
`default_nettype wire

// ==== sltc_ser_model.sv ====
// behavioural remote serializer: back-channel register sink and test word source
// assumes one shared clock; words and strobes change just after the rising edge
`default_nettype none
module sltc_ser_model
    import sltc_pkg::*;
(
    input  wire sltc_bcw_t   i_bcw,   // back-channel write
    input  wire logic        i_clk,   // system clock
    input  wire logic        i_slow,  // stretch ready by three cycles
    input  wire logic [3:0]  i_bad,   // flip first wire bit of next word
    output logic             o_ready, // write accepted
    output logic [3:0]       o_act,   // test mode report per port
    output logic [3:0]       o_valid, // word strobes
    output logic [31:0]      o_word   // words, port 0 low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] hist    = 7'h7f;
    logic [2:0] cnt     = 3'h0;
    logic       test    = 1'b0;
    logic       ext_clk = 1'b1;
    int         crc_err = 0;
    logic [7:0] nw;
    logic [6:0] nh;
    initial
    begin
        o_act = 4'h0;
        o_valid = 4'h0;
        o_word = 32'h0;
    end
    assign o_ready = i_bcw.valid && (cnt == (i_slow ? 3'h3 : 3'h0));
    // serial x^7+x^6+1 sequence, first bit in the word msb
    always_comb
    begin
        nh = hist;
        for (int i = 7; i >= 0; i--)
        begin
            nw[i] = nh[5] ^ nh[6];
            nh = {nh[5:0], nw[i]};
        end
    end
    always @(posedge i_clk)
    begin
        cnt <= (i_bcw.valid && !o_ready) ? cnt + 3'h1 : 3'h0;
        // no crc field on this link: a frame aimed at a register we lack counts as corrupt
        if (o_ready && i_bcw.addr != SER_TEST_REG)
            crc_err <= crc_err + 1;
        if (o_ready && i_bcw.addr == SER_TEST_REG)
        begin
            test <= i_bcw.data[0];
            ext_clk <= (i_bcw.data[2:1] == 2'b00);
        end
        o_act <= {4{test}};
        // flipping the msb spoils one word only: the next prediction never uses it
        if (test)
        begin
            hist <= nh;
            o_valid <= 4'hf;
            o_word <= {4{nw}} ^ {i_bad[3], 7'h0, i_bad[2], 7'h0, i_bad[1], 7'h0, i_bad[0], 7'h0};
        end
        else
        begin
            o_valid <= 4'h0;
            o_word <= ~o_word;
        end
    end
endmodule
`default_nettype wire

// ==== sltc_top_tb.sv ====
// self-checking bench for the link self-test controller
// assumes the serializer model sits on the back channel and word inputs
`default_nettype none
module sltc_top_tb
    import sltc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rstn = 1'b0, slow = 1'b1, rdy, ten, oen, lp11, csi, pgen;
    logic [3:0]  lock = 4'h0, bad = 4'h0, act, vld, pass;
    logic [31:0] word;
    logic [15:0] bc_last;
    sltc_req_t   loc = '0, rem = '0;
    sltc_rsp_t   lrsp, rrsp, rsp;
    sltc_bcw_t   bcw;
    int          err_count = 0, total_checks = 0, bc_n = 0;
    initial forever #20 clk = ~clk;
    sltc_top #(.W(8)) uut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_LOC_REQ(loc), .O_LOC_RSP(lrsp), .I_REM_REQ(rem),
        .O_REM_RSP(rrsp), .I_RX_LOCK(lock), .I_SER_ACT(act), .I_RX_VALID(vld), .I_RX_WORD(word), .O_BC_WR(bcw),
        .I_BC_READY(rdy), .O_PASS(pass), .O_OUT_EN(oen), .O_CSI_LP11(lp11), .O_CSI_EN(csi), .O_PGEN_EN(pgen),
        .O_TEST_ACTIVE(ten));
    sltc_ser_model ser (.i_bcw(bcw), .i_clk(clk), .i_slow(slow), .i_bad(bad), .o_ready(rdy), .o_act(act),
        .o_valid(vld), .o_word(word));
    always @(posedge clk)
        if (bcw.valid && rdy)
        begin
            bc_n <= bc_n + 1;
            bc_last <= {bcw.addr, bcw.data};
        end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // request stands one edge; released a cycle later so no signal changes twice at once
    task automatic bus(input bit r, input bit w, input logic [7:0] a, input logic [7:0] d);
        if (r) rem = {w, !w, a, d};
        else loc = {w, !w, a, d};
        step(1);
        rsp = r ? rrsp : lrsp;
        loc = '0;
        rem = '0;
        step(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, 1'b1, a, d);
    endtask
    task automatic rd(input bit r, input logic [7:0] a, input logic [7:0] exp);
        bus(r, 1'b0, a, 8'h00);
        chk({7'h0, rsp.valid, rsp.data}, {8'h01, exp});
    endtask
    task automatic wait_bc(input int n, input logic [7:0] d);
        for (int i = 0; i < 50 && bc_n < n; i++) step(1);
        if (bc_n < n)
        begin
            chk(16'h0, 16'h1);
            finish_test();
        end
        else
            chk(bc_last, {SER_TEST_REG, d});
    endtask
    task automatic lows(input int p, input int exp);
        int n;
        n = 0;
        repeat (12)
        begin
            step(1);
            n += (pass[p] === 1'b0);
        end
        chk(16'(n), 16'(exp));
    endtask
    initial
    begin
        step(4);
        rstn = 1'b1;
        step(4);
        rd(1'b0, 8'hb3, 8'h00);
        rd(1'b0, 8'h4c, 8'h01);
        rd(1'b0, 8'h80, 8'h00);
        rd(1'b0, 8'h57, 8'hff);
        chk(16'(pass), 16'h000f);
        lock = 4'hf;
        wr(8'hb3, 8'h83);
        wait_bc(1, 8'h03);
        chk(16'(ser.ext_clk), 16'h0);
        chk({13'h0, ten, oen, lp11}, 16'h0007);
        wr(8'hb3, 8'h85);
        step(20);
        chk(16'(bc_n), 16'h1);
        rd(1'b0, 8'hd0, 8'h20);
        bad = 4'h4;
        step(1);
        bad = 4'h0;
        lows(2, 1);
        wr(8'h4c, 8'h2f);
        rd(1'b0, 8'h57, 8'h01);
        wr(8'h4c, 8'h0f);
        rd(1'b0, 8'h57, 8'h00);
        bad = 4'h1;
        step(300);
        bad = 4'h0;
        rd(1'b0, 8'h57, 8'hfe);
        lock = 4'h7;
        step(6);
        wr(8'h4c, 8'h3f);
        rd(1'b1, 8'h57, 8'hff);
        wr(8'h4c, 8'h05);
        wr(8'hd0, 8'hff);
        rd(1'b0, 8'hd0, 8'hff);
        wr(8'h4c, 8'h15);
        rd(1'b0, 8'hd0, 8'h20);
        slow = 1'b0;
        wr(8'hb3, 8'h00);
        wait_bc(2, 8'h00);
        wr(8'hb3, 8'h01);
        wait_bc(3, 8'h01);
        chk(16'(ser.ext_clk), 16'h1);
        chk(16'(oen), 16'h0);
        wr(8'h4c, 8'h0f);
        rd(1'b0, 8'h57, 8'h00);
        wr(8'h33, 8'h01);
        rd(1'b0, 8'h33, 8'h00);
        wr(8'h32, 8'h01);
        wr(8'h33, 8'h01);
        rd(1'b0, 8'h33, 8'h01);
        wr(8'hb0, 8'h00);
        wr(8'hb1, 8'h01);
        wr(8'hb2, 8'h01);
        chk({14'h0, csi, pgen}, 16'h0001);
        chk(16'(ser.crc_err), 16'h0);
        finish_test();
    end
endmodule
`default_nettype wire
